/* motg_map.vh */
`ifndef MOTG_MAP_VH
`define MOTG_MAP_VH

`define MOTG_ADDR_ACTION 12'h627
`define MOTG_ADDR_TRIP 12'h628
`define MOTG_ADDR_LVL1 12'h629
`define MOTG_ADDR_LVL2 12'h62a
`define MOTG_ADDR_DROP 12'h62b
`define MOTG_ADDR_DELAY 12'h62c
`define MOTG_ADDR_FUNC1 12'h402
`define MOTG_ADDR_FUNC2 12'h403
`define MOTG_ADDR_FUNC3 12'h404
`define MOTG_ADDR_STATUS 12'h700
`define MOTG_ADDR_ENABLE 12'h701
`define MOTG_ADDR_CLEAR 12'h702
`define MOTG_ADDR_STATE 12'h703

`define MOTG_RST_ACTION 2'h0
`define MOTG_RST_TRIP 16'h01f4
`define MOTG_RST_LVL1 16'h1388
`define MOTG_RST_LVL2 16'h1b58
`define MOTG_RST_DROP 16'h0000
`define MOTG_RST_DELAY 16'h003c
`define MOTG_RST_FUNC 16'h0000

`define MOTG_ACT_RUN 2'h0
`define MOTG_ACT_RAMP 2'h1
`define MOTG_ACT_COAST 2'h2
`define MOTG_ACT_NONE 2'h3

`define MOTG_FUNC_PTC 16'h0006
`define MOTG_FUNC_RTD 16'h000b

`define MOTG_PCT_TO_MV 16'h000a
`define MOTG_SEC_NS 64'd1000000000
`define MOTG_CLK_NS 64'd20

`define MOTG_ST_WARN1 0
`define MOTG_ST_FAULT2 1
`define MOTG_ST_PTC 2
`define MOTG_ST_DROP 3
`define MOTG_ST_W 4

`endif

/* motg_tick.v */
`timescale 1ns/1ps
`include "motg_map.vh"
module motg_tick #(
   parameter DIV = 50000000
) (
   clk,
   arst_n,
   clr,
   tick
);
   input wire clk;
   input wire arst_n;
   input wire clr;
   output reg tick;

   reg [31:0] cnt_reg;

   // Prescaler restarts with the timer so a delay never runs short by a part second
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= 32'h0;
         tick <= 1'b0;
      end else if (clr) begin
         cnt_reg <= 32'h0;
         tick <= 1'b0;
      end else if (cnt_reg == DIV - 1) begin
         cnt_reg <= 32'h0;
         tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 32'h1;
         tick <= 1'b0;
      end
   end
endmodule

/* motg_delay.v */
`timescale 1ns/1ps
`include "motg_map.vh"
module motg_delay #(
   parameter DIV = 50000000
) (
   clk,
   arst_n,
   restart,
   delay_sec,
   done
);
   input wire clk;
   input wire arst_n;
   input wire restart;
   input wire [15:0] delay_sec;
   output wire done;

   wire tick;
   reg [15:0] sec_reg;

   motg_tick #(.DIV(DIV)) i_motg_tick (
      .clk(clk),
      .arst_n(arst_n),
      .clr(restart),
      .tick(tick)
   );

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sec_reg <= 16'h0;
      end else if (restart) begin
         sec_reg <= 16'h0;
      end else if (tick && !done) begin
         sec_reg <= sec_reg + 16'h1;
      end
   end

   assign done = (sec_reg >= delay_sec) && !restart;
endmodule

/* motg_top.v */
// Function
// - Action code 0 run,1 ramp,2 coast,3 silent
// - Thermistor mode needs code 6, level above zero
// - Resistance-sensor mode selected by code 11
// - Trip level 0-100.0 percent, reset 50.0
// - Level one crossing raises overheat warning
// - Level two crossing faults at once
// - Delay expiry overrides output with drop frequency
// - Drop zero picks thermistor, nonzero resistance sensor
// - Treatment delay 0-6000 s, reset 60
// - Override released after delay again, or at once on leaving resistance-sensor mode
// - Action code ignores level one warnings
`timescale 1ns/1ps
`include "motg_map.vh"
module motg_top #(
   parameter SEC_CYCLES = `MOTG_SEC_NS / `MOTG_CLK_NS
) (
   clk,
   arst_n,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   ai1_mv,
   ai2_mv,
   ai3_mv,
   sample_valid,
   freq_override,
   override_freq,
   overheat_warn,
   overheat_fault,
   ramp_stop,
   coast_stop,
   irq
);
   input wire clk;
   input wire arst_n;
   input wire [11:0] reg_addr;
   input wire [15:0] reg_wdata;
   input wire reg_wr;
   input wire reg_rd;
   output reg [15:0] reg_rdata;
   input wire [15:0] ai1_mv;
   input wire [15:0] ai2_mv;
   input wire [15:0] ai3_mv;
   input wire sample_valid;
   output wire freq_override;
   output reg [15:0] override_freq;
   output reg overheat_warn;
   output reg overheat_fault;
   output reg ramp_stop;
   output reg coast_stop;
   output wire irq;

   localparam S_IDLE = 2'h0;
   localparam S_ARM = 2'h1;
   localparam S_DROP = 2'h2;
   localparam S_REL = 2'h3;

   reg [1:0] action_reg;
   reg [15:0] trip_reg;
   reg [15:0] lvl1_reg;
   reg [15:0] lvl2_reg;
   reg [15:0] drop_reg;
   reg [15:0] delay_reg;
   reg [15:0] func1_reg;
   reg [15:0] func2_reg;
   reg [15:0] func3_reg;
   reg [`MOTG_ST_W-1:0] status_reg;
   reg [`MOTG_ST_W-1:0] status_next;
   reg [`MOTG_ST_W-1:0] enable_reg;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg above1_reg;
   reg above2_reg;
   reg ptc_over_reg;
   reg warn1_reg;
   reg fault2_reg;
   reg ptc_fault_reg;
   reg rd_sel_reg;
   reg [15:0] rd_word_reg;
   reg restart;
   reg [15:0] rd_word;

   wire timer_done;
   wire [15:0] ptc_mv;
   wire [15:0] rtd_mv;
   wire ptc_mode;
   wire rtd_mode;
   wire [`MOTG_ST_W-1:0] events;
   wire [`MOTG_ST_W-1:0] clr_bits;

   // Lowest-numbered input wins if software selects the same code twice
   function [15:0] pick;
      input [15:0] f1;
      input [15:0] f2;
      input [15:0] f3;
      input [15:0] code;
      input [15:0] s1;
      input [15:0] s2;
      input [15:0] s3;
      begin
         if (f1 == code) begin
            pick = s1;
         end else if (f2 == code) begin
            pick = s2;
         end else if (f3 == code) begin
            pick = s3;
         end else begin
            pick = 16'h0;
         end
      end
   endfunction

   function has_code;
      input [15:0] f1;
      input [15:0] f2;
      input [15:0] f3;
      input [15:0] code;
      begin
         has_code = (f1 == code) || (f2 == code) || (f3 == code);
      end
   endfunction

   // Trip level is in 0.1 percent steps; one step equals 10 mV of full scale
   function [31:0] pct_mv;
      input [15:0] pct;
      begin
         pct_mv = pct * `MOTG_PCT_TO_MV;
      end
   endfunction

   assign ptc_mode = has_code(func1_reg, func2_reg, func3_reg, `MOTG_FUNC_PTC) && (trip_reg != 16'h0)
                     && (drop_reg == 16'h0);
   assign rtd_mode = has_code(func1_reg, func2_reg, func3_reg, `MOTG_FUNC_RTD)
                     && (drop_reg != 16'h0);
   assign ptc_mv = pick(func1_reg, func2_reg, func3_reg, `MOTG_FUNC_PTC, ai1_mv, ai2_mv, ai3_mv);
   assign rtd_mv = pick(func1_reg, func2_reg, func3_reg, `MOTG_FUNC_RTD, ai1_mv, ai2_mv, ai3_mv);

   // Comparisons only rise on a fresh sample; leaving the sensor mode clears them at once
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         above1_reg <= 1'b0;
         above2_reg <= 1'b0;
         ptc_over_reg <= 1'b0;
      end else if (sample_valid) begin
         above1_reg <= rtd_mode && (rtd_mv >= lvl1_reg);
         above2_reg <= rtd_mode && (rtd_mv >= lvl2_reg);
         ptc_over_reg <= ptc_mode && ({16'h0, ptc_mv} >= pct_mv(trip_reg));
      end else begin
         above1_reg <= above1_reg && rtd_mode;
         above2_reg <= above2_reg && rtd_mode;
         ptc_over_reg <= ptc_over_reg && ptc_mode;
      end
   end

   // Delay sequencer for the level one frequency drop
   always @* begin
      state_next = state_reg;
      restart = 1'b0;
      case (state_reg)
         S_IDLE: begin
            if (above1_reg) begin
               state_next = S_ARM;
               restart = 1'b1;
            end
         end
         S_ARM: begin
            if (!above1_reg) begin
               state_next = S_IDLE;
            end else if (timer_done) begin
               state_next = S_DROP;
            end
         end
         S_DROP: begin
            if (!above1_reg) begin
               state_next = S_REL;
               restart = 1'b1;
            end
         end
         S_REL: begin
            if (above1_reg) begin
               state_next = S_DROP;
            end else if (timer_done) begin
               state_next = S_IDLE;
            end
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
      if (!rtd_mode) begin
         state_next = S_IDLE;
         restart = 1'b0;
      end
   end

   motg_delay #(.DIV(SEC_CYCLES)) i_motg_delay (
      .clk(clk),
      .arst_n(arst_n),
      .restart(restart),
      .delay_sec(delay_reg),
      .done(timer_done)
   );

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= S_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Override stays through the cooling delay
   assign freq_override = (state_reg == S_DROP) || (state_reg == S_REL);

   // Action outputs; level one warning bypasses the action code
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         warn1_reg <= 1'b0;
         fault2_reg <= 1'b0;
         ptc_fault_reg <= 1'b0;
         overheat_warn <= 1'b0;
         overheat_fault <= 1'b0;
         ramp_stop <= 1'b0;
         coast_stop <= 1'b0;
         override_freq <= 16'h0;
      end else begin
         warn1_reg <= above1_reg;
         fault2_reg <= above2_reg && (action_reg != `MOTG_ACT_NONE);
         ptc_fault_reg <= ptc_over_reg && (action_reg != `MOTG_ACT_NONE);
         overheat_warn <= above1_reg || ((above2_reg || ptc_over_reg) && (action_reg != `MOTG_ACT_NONE));
         overheat_fault <= (above2_reg || ptc_over_reg) && (action_reg != `MOTG_ACT_NONE) &&
                           (action_reg != `MOTG_ACT_RUN);
         ramp_stop <= (above2_reg || ptc_over_reg) && (action_reg == `MOTG_ACT_RAMP);
         coast_stop <= (above2_reg || ptc_over_reg) && (action_reg == `MOTG_ACT_COAST);
         override_freq <= freq_override ? drop_reg : 16'h0;
      end
   end

   // Events are rising edges of the conditions
   assign events[`MOTG_ST_WARN1] = above1_reg && !warn1_reg;
   assign events[`MOTG_ST_FAULT2] = above2_reg && (action_reg != `MOTG_ACT_NONE) && !fault2_reg;
   assign events[`MOTG_ST_PTC] = ptc_over_reg && (action_reg != `MOTG_ACT_NONE) && !ptc_fault_reg;
   assign events[`MOTG_ST_DROP] = (state_next == S_DROP) && (state_reg == S_ARM);
   assign clr_bits = (reg_wr && (reg_addr == `MOTG_ADDR_CLEAR)) ? reg_wdata[`MOTG_ST_W-1:0] :
                     {`MOTG_ST_W{1'b0}};

   // Set beats clear in the same cycle so no event is lost
   always @* begin
      status_next = (status_reg & ~clr_bits) | events;
   end

   assign irq = |(status_reg & enable_reg);

   // Register writes; fields narrower than 16 bits keep the low bits only
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         action_reg <= `MOTG_RST_ACTION;
         trip_reg <= `MOTG_RST_TRIP;
         lvl1_reg <= `MOTG_RST_LVL1;
         lvl2_reg <= `MOTG_RST_LVL2;
         drop_reg <= `MOTG_RST_DROP;
         delay_reg <= `MOTG_RST_DELAY;
         func1_reg <= `MOTG_RST_FUNC;
         func2_reg <= `MOTG_RST_FUNC;
         func3_reg <= `MOTG_RST_FUNC;
         enable_reg <= {`MOTG_ST_W{1'b0}};
         status_reg <= {`MOTG_ST_W{1'b0}};
      end else begin
         status_reg <= status_next;
         if (reg_wr) begin
            case (reg_addr)
               `MOTG_ADDR_ACTION: action_reg <= reg_wdata[1:0];
               `MOTG_ADDR_TRIP: trip_reg <= reg_wdata;
               `MOTG_ADDR_LVL1: lvl1_reg <= reg_wdata;
               `MOTG_ADDR_LVL2: lvl2_reg <= reg_wdata;
               `MOTG_ADDR_DROP: drop_reg <= reg_wdata;
               `MOTG_ADDR_DELAY: delay_reg <= reg_wdata;
               `MOTG_ADDR_FUNC1: func1_reg <= reg_wdata;
               `MOTG_ADDR_FUNC2: func2_reg <= reg_wdata;
               `MOTG_ADDR_FUNC3: func3_reg <= reg_wdata;
               `MOTG_ADDR_ENABLE: enable_reg <= reg_wdata[`MOTG_ST_W-1:0];
               default: begin
               end
            endcase
         end
      end
   end

   always @* begin
      case (reg_addr)
         `MOTG_ADDR_ACTION: rd_word = {14'h0, action_reg};
         `MOTG_ADDR_TRIP: rd_word = trip_reg;
         `MOTG_ADDR_LVL1: rd_word = lvl1_reg;
         `MOTG_ADDR_LVL2: rd_word = lvl2_reg;
         `MOTG_ADDR_DROP: rd_word = drop_reg;
         `MOTG_ADDR_DELAY: rd_word = delay_reg;
         `MOTG_ADDR_FUNC1: rd_word = func1_reg;
         `MOTG_ADDR_FUNC2: rd_word = func2_reg;
         `MOTG_ADDR_FUNC3: rd_word = func3_reg;
         `MOTG_ADDR_STATUS: rd_word = {12'h0, status_reg};
         `MOTG_ADDR_ENABLE: rd_word = {12'h0, enable_reg};
         `MOTG_ADDR_STATE: rd_word = {10'h0, state_reg, above2_reg, above1_reg, ptc_over_reg, freq_override};
         default: rd_word = 16'h0;
      endcase
   end

   // Read data only stands in the cycle after the strobe
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_sel_reg <= 1'b0;
         rd_word_reg <= 16'h0;
      end else begin
         rd_sel_reg <= reg_rd;
         rd_word_reg <= reg_rd ? rd_word : 16'h0;
      end
   end

   always @* begin
      reg_rdata = rd_sel_reg ? rd_word_reg : 16'h0;
   end
endmodule

/* motg_sensor.sv */
`timescale 1ns/1ps
module motg_sensor (
   input wire clk,
   input wire arst_n,
   input wire [15:0] level_mv,
   input wire [1:0] sel,
   output reg [15:0] ai1_mv,
   output reg [15:0] ai2_mv,
   output reg [15:0] ai3_mv,
   output reg sample_valid
);
   reg [1:0] cnt_reg;
   // Slow converter: one sample every four clocks
   // Results move only on the rising edge, so bench changes never reach the block mid-cycle
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= 2'h0;
         sample_valid <= 1'b0;
         ai1_mv <= 16'h0064;
         ai2_mv <= 16'h0064;
         ai3_mv <= 16'h0064;
      end else begin
         cnt_reg <= cnt_reg + 2'h1;
         sample_valid <= (cnt_reg == 2'h3);
         // Unselected inputs sit at a cold-sensor level, never the test level
         ai1_mv <= (sel == 2'h0) ? level_mv : 16'h0064;
         ai2_mv <= (sel == 2'h1) ? level_mv : 16'h0064;
         ai3_mv <= (sel == 2'h2) ? level_mv : 16'h0064;
      end
   end
endmodule

/* motg_top_chk.sv */
`timescale 1ns/1ps
module motg_chk (
   input wire clk,
   input wire arst_n,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_rdata,
   input wire sample_valid,
   input wire freq_override,
   input wire [15:0] override_freq,
   input wire overheat_warn,
   input wire overheat_fault,
   input wire ramp_stop,
   input wire coast_stop
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside read cycle");
   a_stop_needs_fault: assert property ((ramp_stop || coast_stop) |-> overheat_fault)
      else $error("stop request without fault");
   a_stop_one_kind: assert property (!(ramp_stop && coast_stop))
      else $error("ramp and coast together");
   a_fault_has_warn: assert property (overheat_fault |-> overheat_warn)
      else $error("fault without warning");
   a_warn_rise_cause: assert property ($rose(overheat_warn) |->
      $past(sample_valid, 2) || $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
      else $error("warning rose without sample");
   a_fault_move_cause: assert property ($changed(overheat_fault) |->
      $past(sample_valid, 2) || $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
      else $error("fault moved without sample");
   a_ovr_freq_idle: assert property (!freq_override |=> override_freq == 16'h0000)
      else $error("override frequency outside override");
   a_ovr_freq_drop: assert property ($rose(freq_override) |=> override_freq != 16'h0000)
      else $error("override started with zero frequency");
endmodule
bind motg_top motg_chk i_motg_chk (.clk, .arst_n, .reg_wr, .reg_rd, .reg_rdata, .sample_valid, .freq_override,
   .override_freq, .overheat_warn, .overheat_fault, .ramp_stop, .coast_stop);

/* tb_motor_thermal_guard.sv */
`timescale 1ns/1ps
`include "motg_map.vh"
module tb_motor_thermal_guard;
   reg clk = 1'b0;
   reg arst_n = 1'b0;
   reg [11:0] reg_addr = 12'h000;
   reg [15:0] reg_wdata = 16'h0000;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg [15:0] level_mv = 16'h0000;
   reg [1:0] sel = 2'h0;
   wire [15:0] reg_rdata, ai1_mv, ai2_mv, ai3_mv, override_freq;
   wire sample_valid, freq_override, overheat_warn, overheat_fault, ramp_stop, coast_stop, irq;
   integer fail_count = 0;
   integer compares = 0;
   integer i;
   always #10 clk = ~clk;
   motg_top #(.SEC_CYCLES(10)) i_motg_top (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .ai1_mv, .ai2_mv, .ai3_mv, .sample_valid, .freq_override, .override_freq,
      .overheat_warn, .overheat_fault, .ramp_stop, .coast_stop, .irq);
   motg_sensor i_motg_sensor (.clk, .arst_n, .level_mv, .sel, .ai1_mv, .ai2_mv, .ai3_mv, .sample_valid);
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [11:0] a, input [15:0] d);
      begin
         @(posedge clk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge clk);
         reg_wr <= 1'b0;
      end
   endtask
   // Read data only stand in the cycle after the strobe, so sample mid-cycle
   task rd(input [11:0] a, input [15:0] exp);
      begin
         @(posedge clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge clk);
         reg_rd <= 1'b0;
         @(negedge clk);
         chk(reg_rdata, exp);
      end
   endtask
   // Waits cover one sample period plus the two-edge answer
   task outs(input integer n, input [4:0] e);
      begin
         repeat (n) @(posedge clk);
         @(negedge clk);
         chk({11'h000, freq_override, overheat_warn, overheat_fault, ramp_stop, coast_stop}, {11'h000, e});
      end
   endtask
   task print_verdict;
      begin
         $display("compares %0d fail_count %0d", compares, fail_count);
         if (fail_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
         end else begin
            $display("TESTS FAILED");
         end
         $finish;
      end
   endtask
   initial begin
      #100000;
      fail_count = fail_count + 1;
      print_verdict;
   end
   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      rd(`MOTG_ADDR_ACTION, 16'h0000);
      rd(`MOTG_ADDR_TRIP, 16'h01f4);
      rd(`MOTG_ADDR_LVL1, 16'h1388);
      rd(`MOTG_ADDR_LVL2, 16'h1b58);
      rd(`MOTG_ADDR_DROP, 16'h0000);
      rd(`MOTG_ADDR_DELAY, 16'h003c);
      for (i = 0; i < 3; i = i + 1) begin
         rd(`MOTG_ADDR_FUNC1 + i[11:0], 16'h0000);
      end
      wr(`MOTG_ADDR_ACTION, 16'hffff);
      rd(`MOTG_ADDR_ACTION, 16'h0003);
      rd(12'h123, 16'h0000);
      wr(`MOTG_ADDR_STATUS, 16'h000f);
      rd(`MOTG_ADDR_STATUS, 16'h0000);
      wr(`MOTG_ADDR_DROP, 16'he9fc);
      rd(`MOTG_ADDR_DROP, 16'he9fc);
      wr(`MOTG_ADDR_DELAY, 16'h1770);
      rd(`MOTG_ADDR_DELAY, 16'h1770);
      wr(`MOTG_ADDR_TRIP, 16'h03e8);
      rd(`MOTG_ADDR_TRIP, 16'h03e8);
      wr(`MOTG_ADDR_ACTION, 16'h0000);
      wr(`MOTG_ADDR_TRIP, 16'h01f4);
      wr(`MOTG_ADDR_DELAY, 16'h0002);
      wr(`MOTG_ADDR_DROP, 16'h0000);
      wr(`MOTG_ADDR_FUNC1, 16'h000b);
      level_mv <= 16'h1388;
      outs(8, 5'h00);
      wr(`MOTG_ADDR_ENABLE, 16'h0001);
      wr(`MOTG_ADDR_DROP, 16'h03e8);
      outs(8, 5'h08);
      chk({15'h0000, irq}, 16'h0001);
      rd(`MOTG_ADDR_STATUS, 16'h0001);
      wr(`MOTG_ADDR_CLEAR, 16'h0001);
      rd(`MOTG_ADDR_STATUS, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
      outs(30, 5'h18);
      chk(override_freq, 16'h03e8);
      rd(`MOTG_ADDR_STATE, 16'h0025);
      rd(`MOTG_ADDR_STATUS, 16'h0008);
      chk({15'h0000, irq}, 16'h0000);
      level_mv <= 16'h1387;
      outs(8, 5'h10);
      outs(30, 5'h00);
      chk(override_freq, 16'h0000);
      // Long delay proves the second level does not wait for the timer
      wr(`MOTG_ADDR_DELAY, 16'h1770);
      level_mv <= 16'h1b58;
      for (i = 0; i < 4; i = i + 1) begin
         wr(`MOTG_ADDR_ACTION, i[15:0]);
         outs(8, {2'b01, i == 1 || i == 2, i == 1, i == 2});
      end
      level_mv <= 16'h0000;
      outs(8, 5'h00);
      wr(`MOTG_ADDR_ACTION, 16'h0001);
      wr(`MOTG_ADDR_DROP, 16'h0000);
      wr(`MOTG_ADDR_FUNC1, 16'h0000);
      wr(`MOTG_ADDR_FUNC3, 16'h0006);
      sel <= 2'h2;
      level_mv <= 16'h1387;
      outs(8, 5'h00);
      level_mv <= 16'h1388;
      outs(8, 5'h0e);
      wr(`MOTG_ADDR_TRIP, 16'h0000);
      outs(8, 5'h00);
      wr(`MOTG_ADDR_TRIP, 16'h01f4);
      outs(8, 5'h0e);
      wr(`MOTG_ADDR_DROP, 16'h0001);
      outs(8, 5'h00);
      print_verdict;
   end
endmodule
